/* File: common/mcal_pkg.sv */
package mcal_pkg;

   // Datapath widths
   localparam int VOLT_W    = 16;
   localparam int VOLT_FRAC = 14;
   localparam int CUR_W     = 24;
   localparam int CAL_W     = 26;
   localparam int GAIN_W    = 32;
   localparam int COEF_W    = 32;
   localparam int ACC_W     = 48;
   localparam int PROD_W    = CUR_W + GAIN_W;

   // Polynomial order and Horner step counter
   localparam int         POLY_ORDER = 6;
   localparam int         STEP_W     = 3;
   localparam logic [2:0] STEP_FIRST = 3'h5;
   localparam logic [2:0] STEP_LAST  = 3'h0;

   // Gain denominator: gain of 1000 means one percent
   localparam int GAIN_DEN = 100000;

   // Result buffer
   localparam int BUF_DEPTH = 2;

   // Charge state codes
   localparam logic [1:0] CLS_REST = 2'h0;
   localparam logic [1:0] CLS_CHG  = 2'h1;
   localparam logic [1:0] CLS_DIS  = 2'h2;

   // Reset values
   localparam logic [ACC_W-1:0] CHARGE_RST = 48'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_POLY = 3'b010,
      ST_PUSH = 3'b100
   } mcal_state_e;

   typedef logic [POLY_ORDER:0][COEF_W-1:0] mcal_coefs_t;

   typedef struct packed {
      logic        [VOLT_W-1:0] therm_v;
      logic signed [CUR_W-1:0]  stack_raw;
      logic signed [CUR_W-1:0]  bus_raw;
   } mcal_sample_s;

   typedef struct packed {
      logic signed [COEF_W-1:0] temp;
      logic signed [CAL_W-1:0]  stack_cal;
      logic signed [CAL_W-1:0]  bus_cal;
      logic        [1:0]        cls;
   } mcal_result_s;

   localparam int RES_W = $bits(mcal_result_s);

endpackage

/* File: verilog/mcal_buf.sv */
module mcal_buf #(
   parameter int WIDTH = mcal_pkg::RES_W,
   parameter int DEPTH = mcal_pkg::BUF_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [DEPTH-1:0][WIDTH-1:0] data_reg;
   logic [DEPTH-1:0][WIDTH-1:0] data_next;
   logic [CW-1:0]               cnt_reg;
   logic [CW-1:0]               cnt_next;
   logic                        push;
   logic                        pop;

   assign in_ready  = (cnt_reg < CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = data_reg[0];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      logic [CW-1:0] wr;
      wr        = pop ? cnt_reg - CW'(1) : cnt_reg;
      data_next = data_reg;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            data_next[i] = data_reg[i+1];
         end
      end
      if (push) begin
         data_next[wr] = in_data;
      end
      cnt_next = cnt_reg + CW'(push) - CW'(pop);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         data_reg <= '0;
         cnt_reg  <= '0;
      end else begin
         data_reg <= data_next;
         cnt_reg  <= cnt_next;
      end
   end

endmodule

/* File: verilog/mcal_core.sv */
// Functional notes
// - Temperature is sixth-order polynomial of thermistor voltage, seven coefficients.
// - Stack current equals raw times one plus gain over 100000.
// - Gain is signed; 1000 adds one percent, -1000 removes one percent.
// - Gain beyond factory magnitude limit is clamped to limit, sign kept.
// - Bus current uses same scaling with its own gain and limit.
// - Stack at rest when absolute calibrated current not above hold threshold.
// - Charge accumulates from calibrated current on every sample, regardless of class.
// - Charge state classification is exported for other functions.
module mcal_core (
   input  wire logic                                  ref_clk,
   input  wire logic                                  resetn,
   input  wire logic                                  smp_valid,
   output logic                                       smp_ready,
   input  wire mcal_pkg::mcal_sample_s                smp_data,
   input  wire mcal_pkg::mcal_coefs_t                 coeff,
   input  wire logic signed [mcal_pkg::GAIN_W-1:0]    stack_gain,
   input  wire logic        [mcal_pkg::GAIN_W-2:0]    stack_gain_limit,
   input  wire logic signed [mcal_pkg::GAIN_W-1:0]    bus_gain,
   input  wire logic        [mcal_pkg::GAIN_W-2:0]    bus_gain_limit,
   input  wire logic        [mcal_pkg::CUR_W-1:0]     hold_current,
   output logic                                       res_valid,
   input  wire logic                                  res_ready,
   output mcal_pkg::mcal_result_s                     res_data,
   output logic             [1:0]                     charge_state,
   output logic signed      [mcal_pkg::ACC_W-1:0]     charge_acc
);

   function automatic logic signed [mcal_pkg::GAIN_W-1:0] mcal_clamp(
      input logic signed [mcal_pkg::GAIN_W-1:0] g,
      input logic        [mcal_pkg::GAIN_W-2:0] lim
   );
      logic signed [mcal_pkg::GAIN_W-1:0] pos;
      pos = $signed({1'b0, lim});
      if (g > pos) begin
         return pos;
      end else if (g < -pos) begin
         return -pos;
      end
      return g;
   endfunction

   function automatic logic signed [mcal_pkg::CAL_W-1:0] mcal_scale(
      input logic signed [mcal_pkg::CUR_W-1:0]  raw,
      input logic signed [mcal_pkg::GAIN_W-1:0] g
   );
      logic signed [mcal_pkg::PROD_W-1:0] prod;
      logic signed [mcal_pkg::PROD_W-1:0] sum;
      prod = raw * g;
      sum  = prod / mcal_pkg::PROD_W'(mcal_pkg::GAIN_DEN) + mcal_pkg::PROD_W'(raw);
      return mcal_pkg::CAL_W'(sum);
   endfunction

   function automatic logic [1:0] mcal_classify(
      input logic signed [mcal_pkg::CAL_W-1:0] cal,
      input logic        [mcal_pkg::CUR_W-1:0] hold
   );
      logic signed [mcal_pkg::CAL_W:0] c;
      logic signed [mcal_pkg::CAL_W:0] h;
      c = {cal[mcal_pkg::CAL_W-1], cal};
      h = $signed({3'h0, hold});
      if (c > h) begin
         return mcal_pkg::CLS_CHG;
      end else if (c < -h) begin
         return mcal_pkg::CLS_DIS;
      end
      return mcal_pkg::CLS_REST;
   endfunction

   function automatic logic signed [mcal_pkg::COEF_W-1:0] mcal_horner(
      input logic signed [mcal_pkg::COEF_W-1:0] acc,
      input logic        [mcal_pkg::VOLT_W-1:0] v,
      input logic signed [mcal_pkg::COEF_W-1:0] c
   );
      logic signed [mcal_pkg::COEF_W+mcal_pkg::VOLT_W:0] prod;
      prod = acc * $signed({1'b0, v});
      prod = prod >>> mcal_pkg::VOLT_FRAC;
      return mcal_pkg::COEF_W'(prod) + c;
   endfunction

   mcal_pkg::mcal_state_e              st_reg;
   mcal_pkg::mcal_state_e              st_next;
   logic [mcal_pkg::STEP_W-1:0]        step_reg;
   logic [mcal_pkg::STEP_W-1:0]        step_next;
   logic [mcal_pkg::VOLT_W-1:0]        v_reg;
   logic [mcal_pkg::VOLT_W-1:0]        v_next;
   logic signed [mcal_pkg::COEF_W-1:0] temp_reg;
   logic signed [mcal_pkg::COEF_W-1:0] temp_next;
   logic signed [mcal_pkg::CAL_W-1:0]  stack_cal_reg;
   logic signed [mcal_pkg::CAL_W-1:0]  stack_cal_next;
   logic signed [mcal_pkg::CAL_W-1:0]  bus_cal_reg;
   logic signed [mcal_pkg::CAL_W-1:0]  bus_cal_next;
   logic [1:0]                         cls_reg;
   logic [1:0]                         cls_next;
   logic signed [mcal_pkg::ACC_W-1:0]  charge_reg;
   logic signed [mcal_pkg::ACC_W-1:0]  charge_next;
   logic                               accept;
   logic                               buf_ready;
   logic signed [mcal_pkg::CAL_W-1:0]  stack_cal_w;
   mcal_pkg::mcal_result_s             push_data;

   assign smp_ready    = (st_reg == mcal_pkg::ST_IDLE);
   assign accept       = smp_valid && smp_ready;
   assign stack_cal_w  = mcal_scale(smp_data.stack_raw,
                                    mcal_clamp(stack_gain, stack_gain_limit));
   assign charge_state = cls_reg;
   assign charge_acc   = charge_reg;
   assign push_data    = '{temp: temp_reg, stack_cal: stack_cal_reg,
                           bus_cal: bus_cal_reg, cls: cls_reg};

   always_comb begin
      st_next        = st_reg;
      step_next      = step_reg;
      v_next         = v_reg;
      temp_next      = temp_reg;
      stack_cal_next = stack_cal_reg;
      bus_cal_next   = bus_cal_reg;
      cls_next       = cls_reg;
      charge_next    = charge_reg;
      case (st_reg)
         mcal_pkg::ST_IDLE: begin
            if (accept) begin
               v_next         = smp_data.therm_v;
               temp_next      = coeff[mcal_pkg::POLY_ORDER];
               step_next      = mcal_pkg::STEP_FIRST;
               stack_cal_next = stack_cal_w;
               bus_cal_next   = mcal_scale(smp_data.bus_raw,
                                           mcal_clamp(bus_gain, bus_gain_limit));
               cls_next       = mcal_classify(stack_cal_w, hold_current);
               charge_next    = charge_reg + mcal_pkg::ACC_W'(stack_cal_w);
               st_next        = mcal_pkg::ST_POLY;
            end
         end
         mcal_pkg::ST_POLY: begin
            temp_next = mcal_horner(temp_reg, v_reg, coeff[step_reg]);
            if (step_reg == mcal_pkg::STEP_LAST) begin
               st_next = mcal_pkg::ST_PUSH;
            end else begin
               step_next = step_reg - mcal_pkg::STEP_W'(1);
            end
         end
         mcal_pkg::ST_PUSH: begin
            if (buf_ready) begin
               st_next = mcal_pkg::ST_IDLE;
            end
         end
         default: begin
            st_next = mcal_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg        <= mcal_pkg::ST_IDLE;
         step_reg      <= '0;
         v_reg         <= '0;
         temp_reg      <= '0;
         stack_cal_reg <= '0;
         bus_cal_reg   <= '0;
         cls_reg       <= mcal_pkg::CLS_REST;
         charge_reg    <= mcal_pkg::CHARGE_RST;
      end else begin
         st_reg        <= st_next;
         step_reg      <= step_next;
         v_reg         <= v_next;
         temp_reg      <= temp_next;
         stack_cal_reg <= stack_cal_next;
         bus_cal_reg   <= bus_cal_next;
         cls_reg       <= cls_next;
         charge_reg    <= charge_next;
      end
   end

   // Results wait here so a stalled receiver loses nothing
   mcal_buf #(
      .WIDTH (mcal_pkg::RES_W),
      .DEPTH (mcal_pkg::BUF_DEPTH)
   ) u_buf (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .in_valid  (st_reg == mcal_pkg::ST_PUSH),
      .in_ready  (buf_ready),
      .in_data   (push_data),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res_data)
   );

   // Assertion helpers
   logic signed [mcal_pkg::CAL_W-1:0]  chk_stack_lim;
   logic signed [mcal_pkg::CAL_W-1:0]  chk_bus_lim;
   logic signed [mcal_pkg::CAL_W-1:0]  chk_pct;
   logic signed [mcal_pkg::CAL_W:0]    chk_cal_x;
   logic signed [mcal_pkg::CAL_W:0]    chk_hold_x;
   logic signed [mcal_pkg::COEF_W-1:0] chk_c0;

   assign chk_stack_lim = mcal_scale(smp_data.stack_raw, $signed({1'b0, stack_gain_limit}));
   assign chk_bus_lim   = mcal_scale(smp_data.bus_raw, -$signed({1'b0, bus_gain_limit}));
   assign chk_pct       = mcal_pkg::CAL_W'(smp_data.stack_raw)
                          + mcal_pkg::CAL_W'(smp_data.stack_raw / 24'sh64);
   assign chk_cal_x     = {stack_cal_reg[mcal_pkg::CAL_W-1], stack_cal_reg};
   assign chk_hold_x    = $signed({3'h0, hold_current});
   assign chk_c0        = coeff[0];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_gain_pct: assert property (
      accept && stack_gain == 32'sh3e8 && stack_gain_limit >= 31'h3e8
      |=> stack_cal_reg == $past(chk_pct))
      else $error("one percent gain gives wrong stack current");
   chk_stack_clamp: assert property (
      accept && stack_gain > $signed({1'b0, stack_gain_limit})
      |=> stack_cal_reg == $past(chk_stack_lim))
      else $error("stack gain not clamped to limit");
   chk_bus_clamp: assert property (
      accept && bus_gain < -$signed({1'b0, bus_gain_limit})
      |=> bus_cal_reg == $past(chk_bus_lim))
      else $error("bus gain not clamped to negative limit");
   chk_rest_band: assert property (
      accept |=> (cls_reg == mcal_pkg::CLS_REST)
                 == (chk_cal_x <= $past(chk_hold_x) && chk_cal_x >= -$past(chk_hold_x)))
      else $error("rest class disagrees with deadband");
   chk_charge_sign: assert property (
      accept |=> (cls_reg == mcal_pkg::CLS_CHG) == (chk_cal_x > $past(chk_hold_x))
                 && (cls_reg == mcal_pkg::CLS_DIS) == (chk_cal_x < -$past(chk_hold_x)))
      else $error("charge class disagrees with current sign");
   chk_charge_add: assert property (
      accept |=> charge_reg == $past(charge_reg) + mcal_pkg::ACC_W'(stack_cal_reg))
      else $error("charge not accumulated on sample");
   chk_charge_hold: assert property (
      !accept |=> $stable(charge_reg))
      else $error("charge changed without a sample");
   chk_poly_steps: assert property (
      accept |=> st_reg == mcal_pkg::ST_POLY [*6] ##1 st_reg == mcal_pkg::ST_PUSH)
      else $error("polynomial did not take six steps");
   chk_poly_zero: assert property (
      accept && smp_data.therm_v == '0 |-> ##7 temp_reg == $past(chk_c0))
      else $error("zero voltage does not give constant term");
   chk_state_out: assert property (
      !accept |=> $stable(charge_state))
      else $error("charge state output changed without a sample");

   cov_sample: cover property (accept ##7 res_valid);
   cov_clamp:  cover property (accept && stack_gain > $signed({1'b0, stack_gain_limit}));
   cov_rest:   cover property (accept ##1 cls_reg == mcal_pkg::CLS_REST);
   cov_stall:  cover property (st_reg == mcal_pkg::ST_PUSH && !buf_ready);

endmodule

/* File: tb/mcal_fe.sv */
module mcal_fe (
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   input  wire logic                   go,
   input  wire logic [3:0]             dly,
   input  wire mcal_pkg::mcal_sample_s din,
   input  wire logic                   smp_ready,
   output logic                        smp_valid,
   output mcal_pkg::mcal_sample_s      smp_data,
   output logic                        busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic                   taken;
   logic [3:0]             wait_n;
   mcal_pkg::mcal_sample_s lat;
   // Request is latched here, lines change only at the falling edge
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         taken <= 1'b0;
         wait_n <= 4'h0;
         lat <= '0;
      end else begin
         taken <= smp_valid && smp_ready;
         if (smp_valid && smp_ready) begin
            busy <= 1'b0;
         end else if (go && !busy) begin
            busy <= 1'b1;
            wait_n <= dly;
            lat <= din;
         end else if (wait_n != 4'h0) begin
            wait_n <= wait_n - 4'h1;
         end
      end
   end
   // Released data shows the inverse, never the last value
   always @(negedge ref_clk) begin
      if (!resetn) begin
         smp_valid <= 1'b0;
         smp_data <= '0;
      end else if (taken) begin
         smp_valid <= 1'b0;
         smp_data <= ~smp_data;
      end else if (busy && !smp_valid && wait_n == 4'h0) begin
         smp_valid <= 1'b1;
         smp_data <= lat;
      end
   end
endmodule

/* File: tb/test_measurement_calibration.sv */
module test_measurement_calibration;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   ref_clk = 1'b0;
   logic                   resetn = 1'b0;
   logic                   go = 1'b0;
   logic                   res_ready = 1'b0;
   logic [3:0]             dly = 4'h0;
   mcal_pkg::mcal_sample_s din = '0;
   mcal_pkg::mcal_sample_s smp_data;
   logic                   smp_valid;
   logic                   smp_ready;
   logic                   res_valid;
   logic                   fe_busy;
   mcal_pkg::mcal_coefs_t  coeff = '0;
   logic signed [31:0]     stack_gain = 32'h0;
   logic signed [31:0]     bus_gain = 32'h0;
   logic [30:0]            stack_gain_limit = 31'h0;
   logic [30:0]            bus_gain_limit = 31'h0;
   logic [23:0]            hold_current = 24'h0;
   mcal_pkg::mcal_result_s res_data;
   logic [1:0]             charge_state;
   logic signed [47:0]     charge_acc;
   logic signed [47:0]     acc_exp = 48'h0;
   mcal_pkg::mcal_result_s exp_q[$];
   int                     n_fail = 0;
   int                     tests_run = 0;

   always #20 ref_clk = ~ref_clk;

   mcal_core i_dut (.ref_clk, .resetn, .smp_valid, .smp_ready, .smp_data, .coeff, .stack_gain,
      .stack_gain_limit, .bus_gain, .bus_gain_limit, .hold_current, .res_valid, .res_ready,
      .res_data, .charge_state, .charge_acc);
   mcal_fe i_fe (.ref_clk, .resetn, .go, .dly, .din, .smp_ready, .smp_valid, .smp_data,
      .busy(fe_busy));

   task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic signed [25:0] f_cal(logic signed [23:0] raw, logic signed [31:0] g,
                                                logic [30:0] lim);
      longint gl;
      longint ll;
      gl = g;
      ll = lim;
      if (gl > ll) gl = ll;
      else if (gl < -ll) gl = -ll;
      return 26'(raw + (raw * gl) / mcal_pkg::GAIN_DEN);
   endfunction

   function automatic logic [1:0] f_cls(logic signed [25:0] c);
      longint hl;
      hl = hold_current;
      if (c > hl) return mcal_pkg::CLS_CHG;
      if (c < -hl) return mcal_pkg::CLS_DIS;
      return mcal_pkg::CLS_REST;
   endfunction

   function automatic logic signed [31:0] f_temp(logic [15:0] v);
      logic signed [31:0] a;
      a = coeff[6];
      for (int k = 5; k >= 0; k--) begin
         a = 32'((longint'(a) * longint'(v)) >>> 14) + coeff[k];
      end
      return a;
   endfunction

   // Results are judged in arrival order
   always @(posedge ref_clk) begin
      if (resetn && res_valid === 1'b1 && res_ready) begin
         if (exp_q.size() == 0) check("spare result", 1, 0);
         else check("res_data", res_data, exp_q.pop_front());
      end
   end

   task automatic send(logic signed [23:0] rs, logic signed [23:0] rb, logic [15:0] v, bit w);
      mcal_pkg::mcal_result_s e;
      int n;
      e.temp = f_temp(v);
      e.stack_cal = f_cal(rs, stack_gain, stack_gain_limit);
      e.bus_cal = f_cal(rb, bus_gain, bus_gain_limit);
      e.cls = f_cls(e.stack_cal);
      exp_q.push_back(e);
      acc_exp += e.stack_cal;
      din = '{therm_v: v, stack_raw: rs, bus_raw: rb};
      go = 1'b1;
      @(negedge ref_clk);
      go = 1'b0;
      n = 0;
      while (w && fe_busy && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      if (w) begin
         check("sample taken", fe_busy, 0);
         @(negedge ref_clk);
         check("charge_state", charge_state, e.cls);
         check("charge_acc", charge_acc, acc_exp);
      end
   endtask

   task automatic drain(string name);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      check("pending results", exp_q.size(), 0);
      $display("Test %s done", name);
   endtask

   task automatic t_poly();
      logic [15:0] vs[5] = '{16'h0, 16'h2000, 16'h4000, 16'h6000, 16'h8000};
      for (int k = 0; k <= 6; k++) coeff[k] = (k % 2) ? -((k + 1) << 16) : (k + 1) << 16;
      foreach (vs[i]) send(24'h10, 24'h0, vs[i], 1);
      drain("poly");
   endtask

   task automatic t_gain();
      logic signed [31:0] gs[5] = '{32'sh3e8, -32'sh3e8, 32'sh0, 32'sh2710, -32'sh2710};
      hold_current = 24'h32;
      stack_gain_limit = 31'h1388;
      bus_gain_limit = 31'hbb8;
      foreach (gs[i]) begin
         stack_gain = gs[i];
         bus_gain = -gs[i];
         send(i[0] ? -24'sh186a0 : 24'sh186a0, 24'sh186a0, 16'h4000, 1);
      end
      drain("gain");
   endtask

   task automatic t_band();
      logic signed [23:0] rs[5] = '{24'sh64, 24'sh65, -24'sh64, -24'sh65, 24'sh0};
      stack_gain = 32'h0;
      hold_current = 24'h64;
      foreach (rs[i]) send(rs[i], -rs[i], 16'h2000, 1);
      drain("deadband");
   endtask

   task automatic t_stall();
      res_ready = 1'b0;
      dly = 4'h3;
      for (int i = 1; i <= 3; i++) send(24'(i * 300), 24'h7, 16'h4000, 1);
      send(24'h5, 24'h5, 16'h4000, 0);
      repeat (20) @(negedge ref_clk);
      check("smp_ready full", smp_ready, 0);
      check("res_valid held", res_valid, 1);
      res_ready = 1'b1;
      drain("stall");
      @(negedge ref_clk);
      check("res_valid empty", res_valid, 0);
   endtask

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (8000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      check("ready in reset", smp_ready, 1);
      check("valid in reset", res_valid, 0);
      check("data in reset", res_data, 0);
      check("state in reset", charge_state, 0);
      check("acc in reset", charge_acc, 0);
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      res_ready = 1'b1;
      @(negedge ref_clk);
      t_poly();
      t_gain();
      t_band();
      t_stall();
      complete_run();
   end
endmodule
